// *** hdl/mul_loader.sv ***
/*
  mul_loader: per-core patch load trigger and loader.
  Assumes firmware serializes triggers per core, places a valid, aligned,
  kilobyte-granular image, and that memory answers each request once.
  Assumes the register write port and memory run on the core clock, while
  the soft init event may come from a pin and is captured here.
  Assumes the patch read port is driven from logic on the core clock.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - writing trigger register 79H loads patch from address in low/high operands.
// - hard reset discards the loaded patch entirely.
// - soft init keeps the loaded patch in effect.
// - loading the same patch again has no extra side effects; here a reload clears patchActive until its last word is in.
// - each core has its own load facility, unshared with neighbours.
// - any logical processor's load patches the whole core.
module mul_loader (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic softInit,
  input wire mul_pkg::mul_msr_wr_t msrWr,
  output mul_pkg::mul_mem_req_t memReq,
  input wire mul_pkg::mul_mem_rsp_t memRsp,
  input wire logic [mul_pkg::MUL_AW-1:0] patchRdAddr,
  output logic [31:0] patchRdData,
  output logic patchActive,
  output logic loadBusy,
  output logic loadDone,
  output logic [mul_pkg::MUL_THREAD_W-1:0] loadThread
);

  mul_pkg::mul_state_t state_reg, state_next;
  logic [63:0] base_reg;
  logic [mul_pkg::MUL_AW-1:0] count_reg;
  logic reqValid_reg;
  logic [63:0] reqAddr_reg;
  logic [mul_pkg::MUL_SYNC_DEPTH-1:0] initSync_reg;
  logic initLevel_reg;
  logic initSeen_reg;

  // decode of the trigger index, used only by the start logic (startLoad)
  function automatic logic isTrigger(input mul_pkg::mul_msr_wr_t w);
    isTrigger = w.valid && (w.index == mul_pkg::MUL_TRIG_INDEX);
  endfunction : isTrigger

  // state decode, shared by sequencer, request and status logic
  function automatic logic stateIs(input mul_pkg::mul_state_t s,
    input mul_pkg::mul_state_t want);
    stateIs = (s == want);
  endfunction : stateIs

  // decoded conditions of the sequencer
  wire logic inIdle = stateIs(state_reg, mul_pkg::MUL_ST_IDLE);
  wire logic inReq = stateIs(state_reg, mul_pkg::MUL_ST_REQ);
  wire logic inWait = stateIs(state_reg, mul_pkg::MUL_ST_WAIT);
  wire logic busyNext = !stateIs(state_next, mul_pkg::MUL_ST_IDLE);
  wire logic startLoad = inIdle && isTrigger(msrWr);
  wire logic wordIn = inWait && memRsp.ack;
  wire logic lastWord = wordIn && (count_reg == mul_pkg::MUL_LAST_WORD);
  wire logic [63:0] trigAddr = {msrWr.high, msrWr.low};
  wire logic [63:0] wordOffs =
    {56'h0, count_reg} * mul_pkg::MUL_WORD_BYTES;
  wire logic [63:0] nextAddr = base_reg + wordOffs;

  // next-state decode
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      mul_pkg::MUL_ST_IDLE: begin
        // only an idle loader takes a trigger
        if (startLoad) begin
          state_next = mul_pkg::MUL_ST_REQ;
        end
      end
      mul_pkg::MUL_ST_REQ: begin
        state_next = mul_pkg::MUL_ST_WAIT;
      end
      mul_pkg::MUL_ST_WAIT: begin
        // last double word ends the load
        if (lastWord) begin
          state_next = mul_pkg::MUL_ST_IDLE;
        end else if (wordIn) begin
          state_next = mul_pkg::MUL_ST_REQ;
        end
      end
      default: begin
        state_next = mul_pkg::MUL_ST_IDLE;
      end
    endcase
  end

  // sequencer state; softInit is deliberately not a term here
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= mul_pkg::MUL_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // start address from the operands
  // base address latched at the trigger
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      base_reg <= mul_pkg::MUL_ADDR_RESET;
    end else if (startLoad) begin
      base_reg <= trigAddr;
    end
  end

  // words stored in address order
  // word counter over the one-kilobyte image
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= mul_pkg::MUL_FIRST_WORD;
    end else if (startLoad) begin
      count_reg <= mul_pkg::MUL_FIRST_WORD;
    end else if (wordIn && !lastWord) begin
      count_reg <= count_reg + 8'h01;
    end
  end

  // fetch of the image
  // one-cycle memory request per double word
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reqValid_reg <= 1'b0;
      reqAddr_reg <= mul_pkg::MUL_ADDR_RESET;
    end else begin
      reqValid_reg <= inReq;
      reqAddr_reg <= nextAddr;
    end
  end

  // soft init leaves it in effect
  // reload rewrites the same words, no accumulation
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      patchActive <= 1'b0;
    end else if (startLoad) begin
      patchActive <= 1'b0;
    end else if (lastWord) begin
      patchActive <= 1'b1;
    end
  end

  // any thread may trigger, the patch serves the whole core
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      loadThread <= '0;
      loadBusy <= 1'b0;
      loadDone <= 1'b0;
    end else begin
      if (startLoad) begin
        loadThread <= msrWr.thread;
      end
      loadBusy <= busyNext;
      loadDone <= lastWord;
    end
  end

  // outputs straight from flip-flops
  assign memReq.req = reqValid_reg;
  assign memReq.addr = reqAddr_reg;

  mul_patch_ram u_ram (
    .clk(clk),
    .wrEn(wordIn),
    .wrAddr(count_reg),
    .wrData(memRsp.data),
    .rdAddr(patchRdAddr),
    .rdData(patchRdData)
  );

  // soft init pin captured by three flip-flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      initSync_reg <= '0;
    end else begin
      initSync_reg <= {initSync_reg[mul_pkg::MUL_SYNC_DEPTH-2:0], softInit};
    end
  end

  // a change counts once stages two and three agree
  wire logic initMid = initSync_reg[mul_pkg::MUL_SYNC_DEPTH-2];
  wire logic initLast = initSync_reg[mul_pkg::MUL_SYNC_DEPTH-1];
  wire logic initAgree = (initMid == initLast);
  wire logic initRise = initAgree && initLast && !initLevel_reg;

  // filtered init level and its one-cycle event
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      initLevel_reg <= 1'b0;
      initSeen_reg <= 1'b0;
    end else begin
      if (initAgree) begin
        initLevel_reg <= initLast;
      end
      initSeen_reg <= initRise;
    end
  end

  // the init event is observed only; patch and loader ignore it
  wire logic unusedInit = initSeen_reg;

endmodule : mul_loader

// *** common/mul_pkg.sv ***
/*
  mul_pkg: constants, states and carrier types of the patch load block.
  Assumes one instance of the loader per core and a 20 MHz core clock.
*/
package mul_pkg;

  // model-specific register index of the patch load trigger
  localparam logic [31:0] MUL_TRIG_INDEX = 32'h0000_0079;

  // patch image: one kilobyte, held as 256 double words
  localparam int MUL_WORDS = 256;
  localparam int MUL_AW = 8;
  localparam logic [MUL_AW-1:0] MUL_LAST_WORD = 8'hff;
  localparam logic [MUL_AW-1:0] MUL_FIRST_WORD = 8'h00;
  localparam logic [63:0] MUL_WORD_BYTES = 64'h0000_0000_0000_0004;
  localparam logic [63:0] MUL_ADDR_RESET = 64'h0000_0000_0000_0000;

  // logical processors sharing one core
  localparam int MUL_THREAD_W = 1;

  // flip-flops that capture the soft init pin
  localparam int MUL_SYNC_DEPTH = 3;

  // load sequencer states, one-hot
  typedef enum logic [2:0] {
    MUL_ST_IDLE = 3'b001,
    MUL_ST_REQ = 3'b010,
    MUL_ST_WAIT = 3'b100
  } mul_state_t;

  // write of a model-specific register by any logical processor
  typedef struct packed {
    logic valid;
    logic [MUL_THREAD_W-1:0] thread;
    logic [31:0] index;
    logic [31:0] high; // high operand register
    logic [31:0] low; // low operand register
  } mul_msr_wr_t;

  // double-word read request toward memory
  typedef struct packed {
    logic req;
    logic [63:0] addr;
  } mul_mem_req_t;

  // answer from memory
  typedef struct packed {
    logic ack;
    logic [31:0] data;
  } mul_mem_rsp_t;

endpackage : mul_pkg

// *** hdl/mul_patch_ram.sv ***
/*
  mul_patch_ram: storage for the loaded patch of one core.
  Assumes a single clock; read data appear one cycle after the address.
*/
`timescale 1ns/1ps
module mul_patch_ram (
  input wire logic clk,
  input wire logic wrEn,
  input wire logic [mul_pkg::MUL_AW-1:0] wrAddr,
  input wire logic [31:0] wrData,
  input wire logic [mul_pkg::MUL_AW-1:0] rdAddr,
  output logic [31:0] rdData
);

  logic [31:0] mem [mul_pkg::MUL_WORDS];

  // write port and registered read port
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule : mul_patch_ram

// *** verif/mul_loader_asserts.sv ***
/* mul_loader_asserts: port checks of the loader.
   Assumes a bind to every mul_loader. */
`timescale 1ns/1ps
module mul_loader_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire mul_pkg::mul_msr_wr_t msrWr,
  input wire mul_pkg::mul_mem_req_t memReq,
  input wire logic patchActive,
  input wire logic loadBusy,
  input wire logic loadDone,
  input wire logic [mul_pkg::MUL_THREAD_W-1:0] loadThread
);
  // trigger write that the idle loader takes
  wire logic hit = msrWr.index == mul_pkg::MUL_TRIG_INDEX;
  wire logic trig = msrWr.valid && hit && !loadBusy;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_trig_load: assert property (trig |=> loadBusy ##1 (memReq.req &&
    memReq.addr == {$past(msrWr.high, 2), $past(msrWr.low, 2)}))
    else $error("load not started");
  a_reset_clear: assert property ($rose(reset_n) |-> !patchActive)
    else $error("patch kept over reset");
  a_patch_kept: assert property (patchActive && !trig |=> patchActive)
    else $error("patch dropped");
  a_thread_rec: assert property (trig |=>
    loadThread == $past(msrWr.thread)) else $error("thread lost");
  a_req_pulse: assert property (memReq.req |=> !memReq.req)
    else $error("request longer than one cycle");
  a_done_pulse: assert property (loadDone |=> !loadDone)
    else $error("done longer than one cycle");
  a_done_idle: assert property (loadDone |-> !loadBusy && patchActive)
    else $error("done without idle loader and patch");
endmodule : mul_loader_asserts
bind mul_loader mul_loader_asserts mul_loader_asserts_i (.clk, .reset_n,
  .msrWr, .memReq, .patchActive, .loadBusy, .loadDone, .loadThread);

// *** verif/testbench.sv ***
/* testbench: loads, soft init and reset of mul_loader.
   Assumes the bench plays firmware and memory. */
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic softInit = 1'b0;
  mul_pkg::mul_msr_wr_t msrWr = '0;
  mul_pkg::mul_mem_req_t memReq;
  mul_pkg::mul_mem_rsp_t memRsp = '0;
  logic [7:0] patchRdAddr = '0;
  logic [31:0] patchRdData;
  logic patchActive, loadBusy, loadDone, loadThread;
  logic [63:0] base;
  int num_errors = 0, checks_done = 0, k;
  mul_loader mul_loader_i (.clk, .reset_n, .softInit, .msrWr, .memReq,
    .memRsp, .patchRdAddr, .patchRdData, .patchActive, .loadBusy,
    .loadDone, .loadThread);
  // clock and cycle ceiling
  always #25 clk = ~clk;
  initial begin
    repeat (9000) @(posedge clk);
    num_errors++;
    end_sim();
  end
  // expected image word
  function automatic logic [31:0] wordOf(input logic [63:0] a);
    return a[31:0] ^ a[63:32];
  endfunction : wordOf
  // image for this core, double words summing to zero
  function automatic logic [31:0] imgWord(input logic [63:0] b, input int n);
    logic [31:0] s;
    s = '0;
    if (n < 255) return wordOf(b + 4 * n);
    for (int i = 0; i < 255; i++) s -= wordOf(b + 4 * i);
    return s;
  endfunction : imgWord
  task automatic chk(input logic [63:0] seen, exp);
    checks_done++;
    if (seen !== exp) num_errors++;
    if (seen !== exp) $display("MISMATCH %0t %h %h", $time, seen, exp);
  endtask : chk
  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  // trigger, serve 256 words as memory, then random read-back
  task automatic load(input logic t);
    // single trigger write of this loader revision
    @(posedge clk) msrWr <= '{1'b1, t, 32'h79, base[63:32], base[31:0]};
    @(posedge clk) msrWr.valid <= 1'b0;
    for (int n = 0; n < 256; n++) begin
      for (k = 0; k < 9 && memReq.req !== 1'b1; k++) @(negedge clk);
      chk(memReq.req, 1'b1);
      chk(memReq.addr, base + 4 * n);
      chk(loadBusy, 1'b1);
      repeat ($urandom % 3) @(negedge clk);
      // every word of the image is reachable
      @(posedge clk) memRsp <= '{1'b1, imgWord(base, n)};
      msrWr.valid <= n == 9; // trigger while busy is refused
      @(posedge clk) memRsp.ack <= 1'b0;
      msrWr.valid <= 1'b0;
    end
    // no new trigger before the load is done
    for (k = 0; k < 9 && loadDone !== 1'b1; k++) @(negedge clk);
    chk(loadDone, 1'b1);
    chk(loadBusy, 1'b0);
    chk(patchActive, 1'b1);
    chk(loadThread, t);
    repeat (8) begin
      @(posedge clk) patchRdAddr <= 8'($urandom);
      repeat (2) @(negedge clk);
      chk(patchRdData, imgWord(base, patchRdAddr));
    end
  endtask : load
  // main sequence
  initial begin
    void'($urandom(32'he1d0));
    // 64-bit address, 16-byte aligned data past the header
    base = {$urandom, $urandom & 32'hffff_f000} + 48;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk(patchActive, 1'b0);
    chk(loadBusy, 1'b0);
    load(1'b0);
    // soft init pulse; the loader must not react
    @(posedge clk) softInit <= 1'b1;
    @(posedge clk) softInit <= 1'b0;
    repeat (6) @(negedge clk);
    chk(patchActive, 1'b1);
    chk(loadBusy, 1'b0);
    load(1'b1);
    @(posedge clk) reset_n <= 1'b0;
    @(negedge clk);
    chk(patchActive, 1'b0);
    // high operand zero, image inside one 64 KB segment
    base = {32'h0, ($urandom & 32'h000f_0000) | 32'h30};
    @(posedge clk) reset_n <= 1'b1;
    @(negedge clk);
    chk(patchActive, 1'b0);
    chk(memReq.req, 1'b0);
    load(1'b0);
    end_sim();
  end
endmodule : testbench
